/* File: rtl/ptu_timer.sv */
// ptu_timer: prescaled 16-bit down timer with protocol start/stop and Avalon-MM
`timescale 1ns/1ps
`default_nettype none
// How it works
// [R1] auto-start set: transmission end starts the timer in every mode and speed.
// [R2] auto-start set: RF field switch-on starts it when both inversion bits are one.
// [R3] five-bit modes, single receive: timer stops after fifth received bit.
// [R4] other modes, single receive: timer stops after fourth received bit.
// [R5] multiple receive set: reception never stops it; software uses stop-now.
// [R6] auto-start clear: protocol events neither start nor stop the timer.
// [R7] gate field: 00 ungated, 01 multifunction pin, 10 first auxiliary pin.
// [R8] running status shows enable state, not the gate signal.
// [R9] auto-restart set: reload and keep counting instead of halting.
// [R10] auto-restart clear: count to zero then raise the timer flag.
// [R11] 12-bit prescaler: mode low nibble above the prescaler byte.
// [R12] even bit clear: tick every 2*prescaler+1 reference cycles.
// [R13] even bit set: tick every 2*prescaler+2 reference cycles.
// [R14] reload held as high byte then low byte at next address.
// [R15] each start loads the counter with the reload value.
// [R16] reload writes leave a running count alone until next start or auto-restart reload.
// [R17] timer mode register at 2Ah, cleared to 00h on reset.
// [R18] counter readable as high and low read-only bytes.
// [R19] running and gate open: one decrement per prescaled tick.
module ptu_timer
   import ptu_pkg::*;
(
   input  wire logic        clock_i,
   input  wire logic        rst_i,
   // avalon-mm slave, word addressed
   input  wire logic [5:0]  avs_address_i,
   input  wire logic        avs_read_i,
   input  wire logic        avs_write_i,
   input  wire logic [31:0] avs_writedata_i,
   input  wire logic [3:0]  avs_byteenable_i,
   output logic      [31:0] avs_readdata_o,
   output logic             avs_waitrequest_o,
   // protocol events, one-cycle pulses from same-clock logic
   input  wire logic        tx_end_i,
   input  wire logic        rf_on_i,
   input  wire logic        rx_bit_i,
   // asynchronous pins
   input  wire logic        ref_clk_i,
   input  wire logic        multifunction_input_pin_i,
   input  wire logic        first_auxiliary_pin_i,
   // status
   output logic             timer_running_status_o,
   output logic             irq_o
);

   // ---------------- pin synchronisers ----------------
   logic [2:0] ref_sync_ff;
   logic [2:0] multifunction_input_pin_sync_ff;
   logic [2:0] first_auxiliary_pin_sync_ff;
   logic       ref_lvl_ff;
   logic       multifunction_input_pin_lvl_ff;
   logic       first_auxiliary_pin_lvl_ff;

   // three stages; stage one feeds only stage two
   always_ff @(posedge clock_i or posedge rst_i) begin
      if (rst_i) begin
         ref_sync_ff  <= 3'h0;
         multifunction_input_pin_sync_ff <= 3'h0;
         first_auxiliary_pin_sync_ff <= 3'h0;
      end else begin
         ref_sync_ff  <= {ref_sync_ff[1:0], ref_clk_i};
         multifunction_input_pin_sync_ff <= {multifunction_input_pin_sync_ff[1:0], multifunction_input_pin_i};
         first_auxiliary_pin_sync_ff <= {first_auxiliary_pin_sync_ff[1:0], first_auxiliary_pin_i};
      end
   end

   // a level change is accepted once stages two and three agree
   wire nxt_ref_lvl  = (ref_sync_ff[1] == ref_sync_ff[2]) ?
                       ref_sync_ff[2] : ref_lvl_ff;
   wire nxt_multifunction_input_pin_lvl = (multifunction_input_pin_sync_ff[1] == multifunction_input_pin_sync_ff[2]) ?
                       multifunction_input_pin_sync_ff[2] : multifunction_input_pin_lvl_ff;
   wire nxt_first_auxiliary_pin_lvl = (first_auxiliary_pin_sync_ff[1] == first_auxiliary_pin_sync_ff[2]) ?
                       first_auxiliary_pin_sync_ff[2] : first_auxiliary_pin_lvl_ff;

   always_ff @(posedge clock_i or posedge rst_i) begin
      if (rst_i) begin
         ref_lvl_ff  <= 1'b0;
         multifunction_input_pin_lvl_ff <= 1'b0;
         first_auxiliary_pin_lvl_ff <= 1'b0;
      end else begin
         ref_lvl_ff  <= nxt_ref_lvl;
         multifunction_input_pin_lvl_ff <= nxt_multifunction_input_pin_lvl;
         first_auxiliary_pin_lvl_ff <= nxt_first_auxiliary_pin_lvl;
      end
   end

   // one pulse per rising edge of the 13.56 MHz reference
   wire ref_tick = nxt_ref_lvl & ~ref_lvl_ff;

   // ---------------- registers ----------------
   logic [7:0]  timer_mode_ff;
   logic [7:0]  prescaler_low_ff;
   logic [7:0]  reload_high_ff;
   logic [7:0]  reload_low_ff;
   logic [7:0]  proto_cfg_ff;
   logic [7:0]  irq_mask_ff;
   logic [7:0]  irq_status_ff;
   logic        wait_ff;
   logic [31:0] rdata_ff;
   logic        irq_ff;

   // bus handshake: one wait cycle, then the access completes
   wire req      = avs_read_i | avs_write_i;
   wire nxt_wait = ~(req & wait_ff);
   wire wr_go    = avs_write_i & ~wait_ff & avs_byteenable_i[0];
   wire rd_load  = avs_read_i & wait_ff;
   wire [7:0] wbyte = avs_writedata_i[7:0];

   wire wr_mode   = wr_go & (avs_address_i == PTU_IDX_TIMER_MODE); // [R17]
   wire wr_presc  = wr_go & (avs_address_i == PTU_IDX_PRESC_LOW);
   wire wr_rel_hi = wr_go & (avs_address_i == PTU_IDX_RELOAD_HI); // [R14]
   wire wr_rel_lo = wr_go & (avs_address_i == PTU_IDX_RELOAD_LO); // [R14]
   wire wr_cfg    = wr_go & (avs_address_i == PTU_IDX_PROTO_CFG);
   wire wr_mask   = wr_go & (avs_address_i == PTU_IDX_IRQ_MASK);
   wire wr_istat  = wr_go & (avs_address_i == PTU_IDX_IRQ_STATUS);
   wire wr_ctl    = wr_go & (avs_address_i == PTU_IDX_CONTROL);

   wire sw_stop  = wr_ctl & wbyte[PTU_CTL_STOP_NOW];  // [R5]
   wire sw_start = wr_ctl & wbyte[PTU_CTL_START_NOW];

   // configuration decode
   wire        auto_start_bit   = timer_mode_ff[PTU_TM_AUTO_START];
   wire [1:0]  gate_select_field =
               timer_mode_ff[PTU_TM_GATE_HI:PTU_TM_GATE_LO];
   wire        auto_restart_bit = timer_mode_ff[PTU_TM_AUTO_RESTART];
   wire [11:0] presc_value      =
               {timer_mode_ff[PTU_TM_PRESC_HI:0], prescaler_low_ff}; // [R11]
   wire [15:0] reload_value     = {reload_high_ff, reload_low_ff};   // [R14]
   wire        multiple_receive_bit = proto_cfg_ff[PTU_PC_MULTI_RX];
   wire        even_prescale_bit    = proto_cfg_ff[PTU_PC_EVEN_PRESC];
   wire        five_bit_mode        = proto_cfg_ff[PTU_PC_FIVE_BIT];
   wire        rf_on_inv_all        =
               &proto_cfg_ff[PTU_PC_RF_INV_HI:PTU_PC_RF_INV_LO];

   // configuration registers; reset clears them all
   always_ff @(posedge clock_i or posedge rst_i) begin
      if (rst_i) begin
         timer_mode_ff    <= PTU_RST_TIMER_MODE; // [R17]
         prescaler_low_ff <= PTU_RST_PRESC_LOW;
         reload_high_ff   <= PTU_RST_RELOAD;
         reload_low_ff    <= PTU_RST_RELOAD;
         proto_cfg_ff     <= PTU_RST_PROTO_CFG;
         irq_mask_ff      <= PTU_RST_IRQ;
      end else begin
         if (wr_mode)   timer_mode_ff    <= wbyte;
         if (wr_presc)  prescaler_low_ff <= wbyte;
         if (wr_rel_hi) reload_high_ff   <= wbyte; // [R16]
         if (wr_rel_lo) reload_low_ff    <= wbyte; // [R16]
         if (wr_cfg)    proto_cfg_ff     <= wbyte;
         if (wr_mask)   irq_mask_ff      <= wbyte;
      end
   end

   // ---------------- prescaler ----------------
   logic [12:0] div_cnt_ff;
   // divisor minus one: 2p for odd division, 2p+1 for even division
   wire  [12:0] div_last = {presc_value, even_prescale_bit}; // [R12] [R13]
   wire         div_wrap = ref_tick & (div_cnt_ff >= div_last);
   wire  [12:0] nxt_div_cnt;

   // ---------------- timer core ----------------
   ptu_state_t  state_ff;
   ptu_state_t  nxt_state;
   logic [15:0] count_ff;
   logic [15:0] nxt_count;
   logic [2:0]  rx_cnt_ff;
   logic [2:0]  nxt_rx_cnt;

   // protocol start and stop, gated by the auto-start bit
   wire proto_start = auto_start_bit &
                      (tx_end_i | (rf_on_i & rf_on_inv_all)); // [R1] [R2] [R6]
   wire start_evt   = sw_start | proto_start;
   wire [2:0] rx_limit = five_bit_mode ?
                         PTU_RX_STOP_FIVE : PTU_RX_STOP_FOUR; // [R3] [R4]
   wire rx_watch    = auto_start_bit & ~multiple_receive_bit; // [R5] [R6]
   wire rx_stop     = rx_watch & rx_bit_i & (state_ff == PTU_RUN) &
                      (rx_cnt_ff + 3'h1 == rx_limit);         // [R3] [R4]

   // gate decode; code 11 keeps the gate shut
   wire gate_open = (gate_select_field == PTU_GATE_NONE) |
                    ((gate_select_field == PTU_GATE_MULTIFUNCTION_INPUT_PIN) & multifunction_input_pin_lvl_ff) |
                    ((gate_select_field == PTU_GATE_FIRST_AUXILIARY_PIN) & first_auxiliary_pin_lvl_ff); // [R7]
   wire cnt_tick  = (state_ff == PTU_RUN) & gate_open & div_wrap; // [R19]
   wire hit_zero  = cnt_tick & (count_ff == 16'h0000);            // [R10]

   // the prescaler restarts from zero on every start so the first tick
   // is a full period after the load
   assign nxt_div_cnt = (start_evt | div_wrap) ? 13'h0000 :
                        (ref_tick ? div_cnt_ff + 13'h0001 : div_cnt_ff);

   // next state of the counter; a start outranks a stop in one cycle
   always_comb begin
      nxt_state  = state_ff;
      nxt_count  = count_ff;
      nxt_rx_cnt = rx_cnt_ff;
      case (state_ff)
         PTU_IDLE: begin
            if (start_evt) begin
               nxt_state  = PTU_RUN;
               nxt_count  = reload_value; // [R15]
               nxt_rx_cnt = 3'h0;
            end
         end
         PTU_RUN: begin
            if (start_evt) begin
               nxt_count  = reload_value; // [R15]
               nxt_rx_cnt = 3'h0;
            end else if (sw_stop | rx_stop) begin
               nxt_state = PTU_IDLE;      // [R3] [R4] [R5]
            end else begin
               if (rx_watch & rx_bit_i)
                  nxt_rx_cnt = rx_cnt_ff + 3'h1;
               if (hit_zero) begin
                  if (auto_restart_bit) begin
                     nxt_count = reload_value; // [R9]
                  end else begin
                     nxt_state = PTU_IDLE;     // [R10]
                  end
               end else if (cnt_tick) begin
                  nxt_count = count_ff - 16'h0001; // [R19]
               end
            end
         end
         default: begin
            nxt_state = PTU_IDLE;
         end
      endcase
   end

   always_ff @(posedge clock_i or posedge rst_i) begin
      if (rst_i) begin
         state_ff   <= PTU_IDLE;
         count_ff   <= 16'h0000;
         rx_cnt_ff  <= 3'h0;
         div_cnt_ff <= 13'h0000;
      end else begin
         state_ff   <= nxt_state;
         count_ff   <= nxt_count;
         rx_cnt_ff  <= nxt_rx_cnt;
         div_cnt_ff <= nxt_div_cnt;
      end
   end

   // ---------------- interrupts ----------------
   // timer flag also rises on restart so software sees every period
   wire [7:0] irq_set = {6'h00,
                         rx_stop & ~start_evt & ~sw_stop,
                         hit_zero & ~start_evt & ~sw_stop}; // [R10]
   wire [7:0] irq_clr = wr_istat ? wbyte : 8'h00;
   // set wins over a write-one clear in the same cycle
   wire [7:0] nxt_irq_status = (irq_status_ff & ~irq_clr) | irq_set;
   wire       nxt_irq = |(nxt_irq_status & irq_mask_ff);

   always_ff @(posedge clock_i or posedge rst_i) begin
      if (rst_i) begin
         irq_status_ff <= PTU_RST_IRQ;
         irq_ff        <= 1'b0;
      end else begin
         irq_status_ff <= nxt_irq_status;
         irq_ff        <= nxt_irq;
      end
   end

   // ---------------- read path ----------------
   // running shows the enable state only; the gate is not folded in
   wire       running_now = (nxt_state == PTU_RUN); // [R8]
   wire [7:0] status_byte = {7'h00, state_ff == PTU_RUN}; // [R8]
   logic [7:0] rd_byte;

   // unmapped and write-only addresses read as zero
   always_comb begin
      case (avs_address_i)
         PTU_IDX_TIMER_MODE: rd_byte = timer_mode_ff;
         PTU_IDX_PRESC_LOW:  rd_byte = prescaler_low_ff;
         PTU_IDX_RELOAD_HI:  rd_byte = reload_high_ff;
         PTU_IDX_RELOAD_LO:  rd_byte = reload_low_ff;
         PTU_IDX_COUNT_HI:   rd_byte = count_ff[15:8]; // [R18]
         PTU_IDX_COUNT_LO:   rd_byte = count_ff[7:0];  // [R18]
         PTU_IDX_PROTO_CFG:  rd_byte = proto_cfg_ff;
         PTU_IDX_IRQ_MASK:   rd_byte = irq_mask_ff;
         PTU_IDX_IRQ_STATUS: rd_byte = irq_status_ff;
         PTU_IDX_STATUS:     rd_byte = status_byte;
         default:            rd_byte = 8'h00;
      endcase
   end

   logic running_ff;

   // read data is captured during the wait cycle and held while it shows
   always_ff @(posedge clock_i or posedge rst_i) begin
      if (rst_i) begin
         wait_ff    <= 1'b1;
         rdata_ff   <= 32'h0000_0000;
         running_ff <= 1'b0;
      end else begin
         wait_ff    <= nxt_wait;
         running_ff <= running_now;
         if (rd_load)
            rdata_ff <= {24'h00_0000, rd_byte};
      end
   end

   assign avs_readdata_o         = rdata_ff;
   assign avs_waitrequest_o      = wait_ff;
   assign timer_running_status_o = running_ff;
   assign irq_o                  = irq_ff;

endmodule // ptu_timer
`default_nettype wire

/* File: rtl/ptu_pkg.sv */
// ptu_pkg: register map, field positions and reset values of the timer
package ptu_pkg;
   // register indices; byte address on the bus is four times the index
   localparam logic [5:0] PTU_IDX_IRQ_MASK   = 6'h02;
   localparam logic [5:0] PTU_IDX_IRQ_STATUS = 6'h04;
   localparam logic [5:0] PTU_IDX_STATUS     = 6'h07;
   localparam logic [5:0] PTU_IDX_CONTROL    = 6'h0C;
   localparam logic [5:0] PTU_IDX_PROTO_CFG  = 6'h11;
   localparam logic [5:0] PTU_IDX_TIMER_MODE = 6'h2A;
   localparam logic [5:0] PTU_IDX_PRESC_LOW  = 6'h2B;
   localparam logic [5:0] PTU_IDX_RELOAD_HI  = 6'h2C;
   localparam logic [5:0] PTU_IDX_RELOAD_LO  = 6'h2D;
   localparam logic [5:0] PTU_IDX_COUNT_HI   = 6'h2E;
   localparam logic [5:0] PTU_IDX_COUNT_LO   = 6'h2F;

   // reset values
   localparam logic [7:0] PTU_RST_TIMER_MODE = 8'h00;
   localparam logic [7:0] PTU_RST_PRESC_LOW  = 8'h00;
   localparam logic [7:0] PTU_RST_RELOAD     = 8'h00;
   localparam logic [7:0] PTU_RST_PROTO_CFG  = 8'h00;
   localparam logic [7:0] PTU_RST_IRQ        = 8'h00;

   // timer_mode fields
   localparam int PTU_TM_AUTO_START   = 7;
   localparam int PTU_TM_GATE_HI      = 6;
   localparam int PTU_TM_GATE_LO      = 5;
   localparam int PTU_TM_AUTO_RESTART = 4;
   localparam int PTU_TM_PRESC_HI     = 3;

   // control_register fields (write-only strobes, read as zero)
   localparam int PTU_CTL_STOP_NOW  = 7;
   localparam int PTU_CTL_START_NOW = 6;

   // protocol configuration fields
   localparam int PTU_PC_RF_INV_HI    = 1;
   localparam int PTU_PC_RF_INV_LO    = 0;
   localparam int PTU_PC_MULTI_RX     = 2;
   localparam int PTU_PC_FIVE_BIT     = 3;
   localparam int PTU_PC_EVEN_PRESC   = 4;

   // status and interrupt bits
   localparam int PTU_ST_RUNNING      = 0;
   localparam int PTU_IRQ_TIMER       = 0;
   localparam int PTU_IRQ_RX_STOP     = 1;

   // received bits before the timer stops
   localparam logic [2:0] PTU_RX_STOP_FIVE = 3'h5;
   localparam logic [2:0] PTU_RX_STOP_FOUR = 3'h4;

   // gate select codes
   localparam logic [1:0] PTU_GATE_NONE = 2'h0;
   localparam logic [1:0] PTU_GATE_MULTIFUNCTION_INPUT_PIN = 2'h1;
   localparam logic [1:0] PTU_GATE_FIRST_AUXILIARY_PIN = 2'h2;

   typedef enum logic [0:0] {
      PTU_IDLE = 1'b0,
      PTU_RUN  = 1'b1
   } ptu_state_t;
endpackage

/* File: bench/ptu_timer_chk.sv */
// ptu_timer_chk: bus and status assertions on the timer ports
`timescale 1ns/1ps
`default_nettype none
module ptu_timer_chk (
   input wire logic        clock_i,
   input wire logic        rst_i,
   input wire logic        avs_read_i,
   input wire logic        avs_write_i,
   input wire logic [31:0] avs_readdata_o,
   input wire logic        avs_waitrequest_o,
   input wire logic        tx_end_i,
   input wire logic        rf_on_i,
   input wire logic        timer_running_status_o,
   input wire logic        irq_o
);
   default clocking @(posedge clock_i); endclocking
   default disable iff (rst_i);
   wire req = avs_read_i | avs_write_i;
   // a request is taken, then answered for exactly one cycle
   sequence s_taken;
      req && avs_waitrequest_o;
   endsequence
   sequence s_answer;
      !avs_waitrequest_o ##1 avs_waitrequest_o;
   endsequence
   a_wait_one: assert property (s_taken |=> s_answer)
      else $error("bus answer not one cycle after request");
   a_wait_idle: assert property (!req |-> avs_waitrequest_o)
      else $error("waitrequest low without a request");
   a_wait_bound: assert property (req |-> ##[0:2] !avs_waitrequest_o)
      else $error("bus request left unanswered");
   a_upper_zero: assert property (!avs_waitrequest_o |->
      avs_readdata_o[31:8] == 24'h0) else $error("read data upper bits set");
   a_rdata_hold: assert property ($changed(avs_readdata_o) |->
      avs_read_i && !avs_waitrequest_o) else $error("read data moved");
   // a start needs an event or a software write one edge before
   a_start_cause: assert property ($rose(timer_running_status_o) |->
      $past(tx_end_i) || $past(rf_on_i) || $past(avs_write_i))
      else $error("timer started without a cause");
   a_irq_rise: assert property ($rose(irq_o) |-> $past(avs_write_i)
      || $past(avs_write_i, 2) || $past(timer_running_status_o)
      || $past(timer_running_status_o, 2)
      || $past(timer_running_status_o, 3))
      else $error("interrupt rose without a cause");
   // sticky flag: only a bus write may take the interrupt down
   a_irq_fall: assert property ($fell(irq_o) |->
      $past(avs_write_i) || $past(avs_write_i, 2))
      else $error("interrupt dropped without a write");
endmodule // ptu_timer_chk
bind ptu_timer ptu_timer_chk u_chk (.clock_i(clock_i), .rst_i(rst_i),
   .avs_read_i(avs_read_i), .avs_write_i(avs_write_i),
   .avs_readdata_o(avs_readdata_o), .avs_waitrequest_o(avs_waitrequest_o),
   .tx_end_i(tx_end_i), .rf_on_i(rf_on_i), .irq_o(irq_o),
   .timer_running_status_o(timer_running_status_o));
`default_nettype wire

/* File: bench/ptu_timer_tb.sv */
// ptu_timer_tb: self-checking bench for the protocol timer
`timescale 1ns/1ps
`default_nettype none
module ptu_timer_tb;
   import ptu_pkg::*;
   logic        clock_i, rst_i, rd, wr, ref_clk, mf, aux, wreq, run, irq;
   logic [5:0]  adr;
   logic [31:0] wd, rdata;
   logic [2:0]  ev;
   logic [31:0] lfsr = 32'hC522EEC5;
   logic [7:0]  d;
   logic [15:0] c0, c1;
   int          num_errors = 0, n_checks = 0, cyc = 0, t0;
   logic [5:0]  ra[4] = '{PTU_IDX_TIMER_MODE, PTU_IDX_PRESC_LOW,
                          PTU_IDX_RELOAD_HI, PTU_IDX_RELOAD_LO};
   logic [11:0] pv[3] = '{12'h002, 12'h001, 12'h100};
   logic [15:0] rv[3] = '{16'h0003, 16'h0004, 16'h0001};
   logic        evn[3] = '{1'b0, 1'b1, 1'b0};

   ptu_timer uut (.clock_i(clock_i), .rst_i(rst_i), .avs_address_i(adr),
      .avs_read_i(rd), .avs_write_i(wr), .avs_writedata_i(wd),
      .avs_byteenable_i(4'hF), .avs_readdata_o(rdata),
      .avs_waitrequest_o(wreq), .tx_end_i(ev[0]), .rf_on_i(ev[1]),
      .rx_bit_i(ev[2]), .ref_clk_i(ref_clk), .multifunction_input_pin_i(mf),
      .first_auxiliary_pin_i(aux), .timer_running_status_o(run),
      .irq_o(irq));

   initial begin
      clock_i = 1'b0;
      forever #4 clock_i = ~clock_i;
   end
   // reference runs at an eighth of the system clock, free of any frame
   always @(posedge clock_i) begin
      cyc <= cyc + 1;
      if (cyc % 4 == 3) ref_clk <= ~ref_clk;
   end

   function automatic logic [31:0] nxt(input logic [31:0] s);
      return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
   endfunction
   // window opens one tick early; the prescaler restarts from zero at each start
   function automatic logic [15:0] in_win(input int m, p, e, r);
      int t = (2 * p + 1 + e) * 8;
      return 16'(m >= r * t && m <= (r + 1) * t + 32);
   endfunction
   task automatic chk(input string nm, input logic [15:0] e, g);
      n_checks++;
      if (g !== e) begin
         $display("wrong value %s expected %h seen %h", nm, e, g);
         num_errors++;
      end
   endtask
   // one bus cycle held until waitrequest is seen low
   task automatic bus(input logic w, input logic [5:0] a, input logic [7:0] v);
      int n = 0;
      adr <= a;
      wd <= {24'h0, v};
      wr <= w;
      rd <= ~w;
      do begin
         @(posedge clock_i);
         n++;
      end while (wreq !== 1'b0 && n < 50);
      d = rdata[7:0];
      wr <= 1'b0;
      rd <= 1'b0;
      @(posedge clock_i);
   endtask
   task automatic rd16(output logic [15:0] v);
      bus(0, PTU_IDX_COUNT_HI, 8'h00);
      v[15:8] = d;
      bus(0, PTU_IDX_COUNT_LO, 8'h00);
      v[7:0] = d;
   endtask
   task automatic pulse(input int k, input int n);
      repeat (n) begin
         ev[k] <= 1'b1;
         @(posedge clock_i);
         ev[k] <= 1'b0;
         @(posedge clock_i);
      end
      repeat (2) @(posedge clock_i);
   endtask
   task automatic wait_irq;
      int n = 0;
      while (irq !== 1'b1 && n < 20000) begin
         @(posedge clock_i);
         n++;
      end
   endtask
   task automatic tally_and_finish;
      $display("checks %0d errors %0d", n_checks, num_errors);
      if (num_errors == 0 && n_checks > 0) $display("All checks passed");
      else $display("Checks failed");
      $finish;
   endtask

   initial begin
      repeat (40000) @(posedge clock_i);
      num_errors++;
      tally_and_finish();
   end

   initial begin
      {rst_i, rd, wr, adr, wd, ev, ref_clk, mf, aux} = '0;
      rst_i = 1'b1;
      repeat (3) @(posedge clock_i);
      rst_i <= 1'b0;
      // reset values, random read-back, unmapped and read-only places
      foreach (ra[i]) begin
         bus(0, ra[i], 8'h00);
         chk("reset", 16'h0000, {8'h0, d});
         lfsr = nxt(lfsr);
         bus(1, ra[i], lfsr[7:0]);
         bus(0, ra[i], 8'h00);
         chk("readback", {8'h0, lfsr[7:0]}, {8'h0, d});
      end
      bus(1, 6'h30, 8'hFF);
      bus(0, 6'h30, 8'h00);
      chk("unmapped", 16'h0000, {8'h0, d});
      bus(1, PTU_IDX_COUNT_HI, 8'hFF);
      bus(0, PTU_IDX_COUNT_HI, 8'h00);
      chk("count ro", 16'h0000, {8'h0, d});
      // one-shot periods, reload rewritten while counting
      bus(1, PTU_IDX_IRQ_MASK, 8'h01);
      for (int i = 0; i < 3; i++) begin
         bus(1, PTU_IDX_PROTO_CFG, {3'h0, evn[i], 4'h0});
         bus(1, PTU_IDX_PRESC_LOW, pv[i][7:0]);
         bus(1, PTU_IDX_RELOAD_HI, rv[i][15:8]);
         bus(1, PTU_IDX_RELOAD_LO, rv[i][7:0]);
         bus(1, PTU_IDX_TIMER_MODE, {4'h8, pv[i][11:8]});
         bus(1, PTU_IDX_IRQ_STATUS, 8'h03);
         t0 = cyc;
         pulse(0, 1);
         bus(1, PTU_IDX_RELOAD_LO, 8'hF0);
         wait_irq();
         chk("irq out", 16'h0001, {15'h0, irq});
         chk("period", 16'h0001, in_win(cyc - t0, pv[i], evn[i], rv[i]));
         rd16(c0);
         chk("count end", 16'h0000, c0);
         chk("stopped", 16'h0000, {15'h0, run});
         bus(0, PTU_IDX_IRQ_STATUS, 8'h00);
         chk("timer flag", 16'h0001, {8'h0, d});
         bus(0, PTU_IDX_STATUS, 8'h00);
         chk("status idle", 16'h0000, {8'h0, d});
      end
      // auto-restart keeps running, period is reload plus one ticks
      bus(1, PTU_IDX_PROTO_CFG, 8'h00);
      bus(1, PTU_IDX_PRESC_LOW, 8'h02);
      bus(1, PTU_IDX_RELOAD_LO, 8'h03);
      bus(1, PTU_IDX_IRQ_STATUS, 8'h03);
      bus(1, PTU_IDX_TIMER_MODE, 8'h90);
      pulse(0, 1);
      wait_irq();
      t0 = cyc;
      bus(1, PTU_IDX_IRQ_STATUS, 8'h01);
      repeat (2) @(posedge clock_i);
      wait_irq();
      chk("restart", 16'h0001, 16'(cyc - t0 >= 152 && cyc - t0 <= 168));
      chk("restart run", 16'h0001, {15'h0, run});
      bus(1, PTU_IDX_CONTROL, 8'h80);
      chk("stop now", 16'h0000, {15'h0, run});
      // protocol events without auto-start, then with it
      bus(1, PTU_IDX_PRESC_LOW, 8'h00);
      bus(1, PTU_IDX_RELOAD_HI, 8'hFF);
      bus(1, PTU_IDX_TIMER_MODE, 8'h00);
      bus(1, PTU_IDX_PROTO_CFG, 8'h03);
      pulse(0, 1);
      pulse(1, 1);
      chk("no auto", 16'h0000, {15'h0, run});
      bus(1, PTU_IDX_CONTROL, 8'h40);
      pulse(2, 5);
      chk("no rx stop", 16'h0001, {15'h0, run});
      bus(1, PTU_IDX_CONTROL, 8'h80);
      bus(1, PTU_IDX_TIMER_MODE, 8'h80);
      bus(1, PTU_IDX_PROTO_CFG, 8'h01);
      pulse(1, 1);
      chk("rf one inv", 16'h0000, {15'h0, run});
      bus(1, PTU_IDX_PROTO_CFG, 8'h03);
      pulse(1, 1);
      chk("rf start", 16'h0001, {15'h0, run});
      bus(1, PTU_IDX_CONTROL, 8'h80);
      // stop after the fourth or fifth received bit
      for (int f = 0; f < 2; f++) begin
         bus(1, PTU_IDX_PROTO_CFG, {4'h0, f[0], 3'h0});
         pulse(0, 1);
         pulse(2, 3 + f);
         chk("rx early", 16'h0001, {15'h0, run});
         pulse(2, 1);
         chk("rx stop", 16'h0000, {15'h0, run});
      end
      // rx stop flag sticks beside the timer flag left by the restart run
      bus(0, PTU_IDX_IRQ_STATUS, 8'h00);
      chk("rx flag", 16'h0003, {8'h0, d});
      bus(1, PTU_IDX_PROTO_CFG, 8'h04);
      pulse(0, 1);
      pulse(2, 6);
      chk("multi rx", 16'h0001, {15'h0, run});
      bus(1, PTU_IDX_CONTROL, 8'h80);
      chk("multi stop", 16'h0000, {15'h0, run});
      // gate codes: the other pin must not open the gate
      for (int g = 1; g < 3; g++) begin
         bus(1, PTU_IDX_TIMER_MODE, {1'b0, g[1:0], 5'h0});
         if (g == 1) aux <= 1'b1;
         else mf <= 1'b1;
         bus(1, PTU_IDX_CONTROL, 8'h40);
         repeat (40) @(posedge clock_i);
         rd16(c0);
         repeat (80) @(posedge clock_i);
         rd16(c1);
         chk("gate shut", c0, c1);
         chk("gated run", 16'h0001, {15'h0, run});
         bus(0, PTU_IDX_STATUS, 8'h00);
         chk("status gated", 16'h0001, {8'h0, d});
         if (g == 1) mf <= 1'b1;
         else aux <= 1'b1;
         repeat (80) @(posedge clock_i);
         rd16(c1);
         chk("gate open", 16'h0001, 16'(c1 < c0));
         bus(1, PTU_IDX_CONTROL, 8'h80);
         mf <= 1'b0;
         aux <= 1'b0;
      end
      tally_and_finish();
   end
endmodule // ptu_timer_tb
`default_nettype wire
